//--- fcs_flash_cmd_seq.sv
// How it works
// RULE1 - Software loads 0x03, address, phrase count
// RULE2 - Clearing complete flag launches; flag sets after
// RULE3 - Non-blank section sets both status bits
// RULE4 - Index pointer not 010 gives access error
// RULE5 - Command not allowed in mode: access error
// RULE6 - Address outside program flash: access error
// RULE7 - Phrase address low bits nonzero: access error
// RULE8 - Section crossing boundary errors; no violation
// RULE9 - Read or blank errors set status bits
// RULE10 - Read-once reaches eight phrase reserved field
// RULE11 - Read-once phrase index returns words from 010
// RULE12 - Software avoids running read-once from flash
// RULE13 - Erase all needs every protect open bit
// RULE14 - Block erase; data block needs open bit
// RULE15 - Unsecure erases everything, releases security
// RULE16 - User margin level for data array
// RULE17 - Field margin level only in special mode
// RULE18 - Data array erase verify over word count
// RULE19 - Program one to four data words
// RULE20 - Erase one data array sector
// RULE21 - Program flash reads during data array ops
// RULE22 - Rejected launch starts nothing, flag stays
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module fcs_flash_cmd_seq
    import fcs_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr
);
    typedef enum logic {FCS_IDLE, FCS_RUN} fcs_state_t;

    fcs_state_t  state_q;
    logic [15:0] param_q [NPARAM];
    logic [15:0] pf_mem  [PF_WORDS];
    logic [15:0] ee_mem  [EE_WORDS];
    logic [15:0] ro_mem  [RO_WORDS];
    logic [2:0]  ptr_q;
    logic        command_complete_flag_q;
    logic        access_error_flag_q;
    logic        protection_violation_flag_q;
    logic        mg1_q;
    logic        mg0_q;
    logic        secure_q;
    logic [2:0]  pprot_q;
    logic        dprot_q;
    logic        special_q;
    logic [2:0]  umrg_q;
    logic [2:0]  fmrg_q;
    logic [10:0] waddr_q;
    logic [7:0]  cmd_q;
    logic [10:0] cnt_q;
    logic [10:0] len_q;
    logic [10:0] base_q;
    logic        sel_ee_q;

    logic        setup_acc;
    logic        bus_done;
    logic        wr;
    logic        launch;
    logic        start;
    logic        pf_busy;
    logic [31:0] rdata;
    logic        rerr;
    logic [15:0] win_rd;
    logic [7:0]  ck_cmd;
    logic [17:0] ga;
    logic [15:0] cnt_w;
    logic [17:0] pf_off;
    logic [17:0] ee_off;
    logic        in_pf;
    logic        in_ee;
    logic [19:0] pf_end;
    logic [16:0] ee_end;
    logic [16:0] pg_end;
    logic [2:0]  n_words;
    logic        ck_acc;
    logic        ck_viol;
    logic [10:0] ck_base;
    logic [10:0] ck_len;
    logic        ck_ee;
    logic [10:0] idx;
    logic        last;
    logic        blank_fail;
    logic        pf_we;
    logic        ee_we;
    logic        ro_we;
    logic [9:0]  pf_wa;
    logic [15:0] pf_wd;
    logic [15:0] ee_wd;

    function automatic logic wr_at(
        input logic       en,
        input logic [7:0] a,
        input logic [7:0] ofs
    );
        return en && (a == ofs);
    endfunction

    function automatic logic is_ee_op(
        input logic [7:0] c,
        input logic       sel
    );
        return (c == CMD_EVEE) || (c == CMD_PGEE) ||
               (c == CMD_SEEE) || ((c == CMD_EBLK) && sel);
    endfunction

    // -----------------------------------------------------------
    // APB slave
    // -----------------------------------------------------------
    assign setup_acc = psel && penable && !pready;
    assign bus_done  = psel && penable && pready;
    assign wr        = bus_done && pwrite;
    // RULE2 launch on clear
    assign launch = wr_at(wr, paddr, OFS_STAT) &&
                    pwdata[ST_COMMAND_COMPLETE_FLAG] && command_complete_flag_q &&
                    (state_q == FCS_IDLE);
    // RULE22 errors block start
    assign start = launch && !ck_acc && !ck_viol &&
                   (ck_len != 11'h0);
    // RULE21 pflash reads during data ops
    assign pf_busy = (state_q == FCS_RUN) &&
                     !is_ee_op(cmd_q, sel_ee_q);
    assign win_rd = waddr_q[10] ? ro_mem[waddr_q[4:0]]
                                : pf_mem[waddr_q[9:0]];

    always_comb begin
        rdata = 32'h0;
        rerr  = 1'b0;
        case (paddr)
            OFS_STAT: begin
                rdata[ST_MG0]  = mg0_q;
                rdata[ST_MG1]  = mg1_q;
                rdata[ST_VIOL] = protection_violation_flag_q;
                rdata[ST_ACC]  = access_error_flag_q;
                rdata[ST_COMMAND_COMPLETE_FLAG] = command_complete_flag_q;
                rdata[ST_SEC]  = secure_q;
            end
            OFS_PTR:   rdata[2:0] = ptr_q;
            OFS_DATA: begin
                if (ptr_q <= IX_LAST) begin
                    rdata[15:0] = param_q[ptr_q];
                end
            end
            OFS_PPROT: rdata[2:0] = pprot_q;
            OFS_DPROT: rdata[0] = dprot_q;
            OFS_CFG:   rdata[0] = special_q;
            OFS_MRG: begin
                rdata[2:0] = umrg_q;
                rdata[MRG_FLD+2:MRG_FLD] = fmrg_q;
            end
            OFS_WADDR: rdata[10:0] = waddr_q;
            OFS_WDATA: begin
                rerr = pf_busy ||
                       (pwrite && (state_q == FCS_RUN));
                if (!pf_busy) begin
                    rdata[15:0] = win_rd;
                end
            end
            default: rerr = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_acc;
            if (setup_acc) begin
                prdata  <= pwrite ? 32'h0 : rdata;
                pslverr <= rerr;
            end
        end
    end

    // -----------------------------------------------------------
    // Control registers
    // -----------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_q     <= IX_CMD;
            pprot_q   <= PPROT_RST;
            dprot_q   <= DPROT_RST;
            special_q <= CFG_RST;
            waddr_q   <= 11'h0;
        end else begin
            if (wr_at(wr, paddr, OFS_PTR)) begin
                ptr_q <= pwdata[2:0];
            end
            if (wr_at(wr, paddr, OFS_PPROT)) begin
                pprot_q <= pwdata[2:0];
            end
            if (wr_at(wr, paddr, OFS_DPROT)) begin
                dprot_q <= pwdata[0];
            end
            if (wr_at(wr, paddr, OFS_CFG)) begin
                special_q <= pwdata[0];
            end
            if (wr_at(wr, paddr, OFS_WADDR)) begin
                waddr_q <= pwdata[10:0];
            end
        end
    end

    // -----------------------------------------------------------
    // Launch checks
    // -----------------------------------------------------------
    always_comb begin
        ck_cmd  = param_q[IX_CMD][15:8];
        ga      = {param_q[IX_CMD][1:0], param_q[IX_ADR]};
        cnt_w   = param_q[IX_CNT];
        pf_off  = ga - PF_BASE;
        ee_off  = ga - EE_BASE;
        in_pf   = ga >= PF_BASE;
        in_ee   = (ga >= EE_BASE) && (ga < EE_END);
        pf_end  = {2'b00, pf_off} + {1'b0, cnt_w, 3'b000};
        ee_end  = {10'h0, ee_off[7:1]} + {1'b0, cnt_w};
        n_words = ptr_q - 3'h1;
        pg_end  = {10'h0, ee_off[7:1]} + {14'h0, n_words};
        ck_acc  = 1'b0;
        ck_viol = 1'b0;
        ck_base = 11'h0;
        ck_len  = 11'h0;
        ck_ee   = 1'b0;
        case (ck_cmd)
            CMD_EVPF: begin
                // RULE4 pointer at 010
                ck_acc = ptr_q != IX_CNT;
                // RULE6 program flash range
                if (!in_pf) ck_acc = 1'b1;
                // RULE7 phrase alignment
                if (ga[2:0] != 3'h0) ck_acc = 1'b1;
                // RULE8 boundary crossing
                if (pf_end > PF_SIZE) ck_acc = 1'b1;
                if (cnt_w == 16'h0) ck_acc = 1'b1;
                ck_base = {1'b0, pf_off[10:1]};
                ck_len  = {cnt_w[8:0], 2'b00};
            end
            CMD_RO: begin
                // RULE11 phrase index range
                ck_acc  = (ptr_q != IX_ADR) ||
                          (param_q[IX_ADR] > RO_MAX);
                ck_base = {6'h0, param_q[IX_ADR][2:0], 2'b00};
                ck_len  = BLK_LEN;
            end
            CMD_EALL: begin
                // RULE13 all protection open
                ck_acc  = ptr_q != IX_CMD;
                ck_viol = (pprot_q != PPROT_ALL) || !dprot_q;
                ck_len  = PF_LEN;
            end
            CMD_EBLK: begin
                // RULE14 block select and open bit
                ck_acc = (ptr_q != IX_ADR) || !(in_ee || in_pf);
                ck_ee  = in_ee;
                if (in_ee) begin
                    ck_viol = !dprot_q;
                    ck_len  = EE_LEN;
                end else begin
                    ck_viol = pprot_q != PPROT_ALL;
                    ck_len  = PF_LEN;
                end
            end
            CMD_UNS: begin
                ck_acc = ptr_q != IX_CMD;
                ck_len = PF_LEN;
            end
            CMD_UMRG: begin
                ck_acc = (ptr_q != IX_ADR) ||
                         (param_q[IX_ADR] > {13'h0, UMRG_MAX});
            end
            CMD_FMRG: begin
                // RULE17 special mode only
                ck_acc = !special_q || (ptr_q != IX_ADR) ||
                         (param_q[IX_ADR] > {13'h0, FMRG_MAX});
            end
            CMD_EVEE: begin
                // RULE18 word range check
                ck_acc  = (ptr_q != IX_CNT) || !in_ee || ga[0] ||
                          (cnt_w == 16'h0) || (ee_end > EE_LIM);
                ck_base = {4'h0, ee_off[7:1]};
                ck_len  = cnt_w[10:0];
                ck_ee   = 1'b1;
            end
            CMD_PGEE: begin
                // RULE19 one to four words
                ck_acc  = (ptr_q < IX_CNT) || (ptr_q > IX_LAST) ||
                          !in_ee || ga[0] || (pg_end > EE_LIM);
                ck_base = {4'h0, ee_off[7:1]};
                ck_len  = {8'h0, n_words};
                ck_ee   = 1'b1;
            end
            CMD_SEEE: begin
                // RULE20 sector aligned erase
                ck_acc  = (ptr_q != IX_ADR) || !in_ee || ga[0];
                ck_base = {4'h0, ee_off[7:3], 2'b00};
                ck_len  = BLK_LEN;
                ck_ee   = 1'b1;
            end
            // RULE5 unknown in any mode
            default: ck_acc = 1'b1;
        endcase
    end

    // -----------------------------------------------------------
    // Sequencer
    // -----------------------------------------------------------
    assign idx  = base_q + cnt_q;
    assign last = cnt_q == (len_q - 11'h1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q  <= FCS_IDLE;
            cmd_q    <= 8'h0;
            cnt_q    <= 11'h0;
            len_q    <= 11'h0;
            base_q   <= 11'h0;
            sel_ee_q <= 1'b0;
        end else begin
            case (state_q)
                FCS_IDLE: begin
                    if (start) begin
                        state_q  <= FCS_RUN;
                        cmd_q    <= ck_cmd;
                        cnt_q    <= 11'h0;
                        len_q    <= ck_len;
                        base_q   <= ck_base;
                        sel_ee_q <= ck_ee;
                    end
                end
                FCS_RUN: begin
                    cnt_q <= cnt_q + 11'h1;
                    if (last) begin
                        state_q <= FCS_IDLE;
                    end
                end
                default: state_q <= FCS_IDLE;
            endcase
        end
    end

    always_comb begin
        blank_fail = 1'b0;
        pf_we = 1'b0;
        ee_we = 1'b0;
        ro_we = 1'b0;
        pf_wa = idx[9:0];
        pf_wd = ERASED;
        ee_wd = ERASED;
        if (state_q == FCS_RUN) begin
            case (cmd_q)
                // RULE3 blank check
                CMD_EVPF: blank_fail = pf_mem[idx[9:0]] != ERASED;
                CMD_EVEE: blank_fail = ee_mem[idx[6:0]] != ERASED;
                // RULE15 erase everything
                CMD_EALL, CMD_UNS: begin
                    pf_we = 1'b1;
                    ee_we = cnt_q < EE_LEN;
                end
                CMD_EBLK: begin
                    pf_we = !sel_ee_q;
                    ee_we = sel_ee_q;
                end
                CMD_SEEE: ee_we = 1'b1;
                CMD_PGEE: begin
                    ee_we = 1'b1;
                    ee_wd = param_q[cnt_q[2:0] + IX_CNT];
                end
                default: ee_we = 1'b0;
            endcase
        end else if (wr_at(wr, paddr, OFS_WDATA)) begin
            // Test window write, only while idle
            pf_we = !waddr_q[10];
            ro_we = waddr_q[10];
            pf_wa = waddr_q[9:0];
            pf_wd = pwdata[15:0];
        end
    end

    // Arrays hold no reset; contents are unknown until erased or written
    always_ff @(posedge pclk) begin
        if (pf_we) begin
            pf_mem[pf_wa] <= pf_wd;
        end
        if (ee_we) begin
            ee_mem[idx[6:0]] <= ee_wd;
        end
        if (ro_we) begin
            ro_mem[waddr_q[4:0]] <= pwdata[15:0];
        end
    end

    // -----------------------------------------------------------
    // Parameter array
    // -----------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NPARAM; i++) begin
                param_q[i] <= 16'h0;
            end
        end else begin
            // Writes while busy are dropped to keep the command stable
            if (wr_at(wr, paddr, OFS_DATA) && command_complete_flag_q &&
                (ptr_q <= IX_LAST)) begin
                param_q[ptr_q] <= pwdata[15:0];
            end
            // RULE10 read-once field copy
            if ((state_q == FCS_RUN) && (cmd_q == CMD_RO)) begin
                param_q[cnt_q[2:0] + IX_CNT] <= ro_mem[idx[4:0]];
            end
        end
    end

    // -----------------------------------------------------------
    // Status flags; a hardware set wins over a software clear
    // -----------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            command_complete_flag_q   <= 1'b1;
            access_error_flag_q <= 1'b0;
            protection_violation_flag_q <= 1'b0;
            mg1_q    <= 1'b0;
            mg0_q    <= 1'b0;
            secure_q <= SEC_RST;
            umrg_q   <= 3'h0;
            fmrg_q   <= 3'h0;
        end else begin
            if (wr_at(wr, paddr, OFS_STAT)) begin
                if (pwdata[ST_ACC]) access_error_flag_q <= 1'b0;
                if (pwdata[ST_VIOL]) protection_violation_flag_q <= 1'b0;
            end
            if (launch) begin
                mg1_q <= 1'b0;
                mg0_q <= 1'b0;
                // RULE22 rejected launch keeps flag
                if (ck_acc) begin
                    access_error_flag_q <= 1'b1;
                end else if (ck_viol) begin
                    protection_violation_flag_q <= 1'b1;
                end else if (ck_len != 11'h0) begin
                    command_complete_flag_q <= 1'b0;
                end else if (ck_cmd == CMD_UMRG) begin
                    // RULE16 user margin select
                    umrg_q <= param_q[IX_ADR][2:0];
                end else begin
                    fmrg_q <= param_q[IX_ADR][2:0];
                end
            end
            // RULE9 blank failure sets both
            if (blank_fail) begin
                mg1_q <= 1'b1;
                mg0_q <= 1'b1;
            end
            // RULE2 completion sets flag
            if ((state_q == FCS_RUN) && last) begin
                command_complete_flag_q <= 1'b1;
                if (cmd_q == CMD_UNS) secure_q <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    launch_clears_a: assert property ( // RULE2
        start |=> !command_complete_flag_q && (state_q == FCS_RUN))
        else $error("launch did not start command");
    done_sets_a: assert property ( // RULE2
        (state_q == FCS_RUN) && last |=>
        command_complete_flag_q && (state_q == FCS_IDLE))
        else $error("completion did not set flag");
    blank_status_a: assert property ( // RULE3
        blank_fail |=> mg1_q && mg0_q)
        else $error("blank failure not reported");
    ptr_err_a: assert property ( // RULE4
        launch && (ck_cmd == CMD_EVPF) && (ptr_q != IX_CNT)
        |=> access_error_flag_q && command_complete_flag_q)
        else $error("pointer error not flagged");
    mode_err_a: assert property ( // RULE5
        launch && (ck_cmd == CMD_FMRG) && !special_q
        |=> access_error_flag_q && (fmrg_q == $past(fmrg_q)))
        else $error("mode error not flagged");
    range_err_a: assert property ( // RULE6
        launch && (ck_cmd == CMD_EVPF) && !in_pf |=> access_error_flag_q)
        else $error("range error not flagged");
    align_err_a: assert property ( // RULE7
        launch && (ck_cmd == CMD_EVPF) && (ga[2:0] != 3'h0)
        |=> access_error_flag_q)
        else $error("alignment error not flagged");
    no_viol_a: assert property ( // RULE8
        launch && (ck_cmd == CMD_EVPF) |=> !$rose(protection_violation_flag_q))
        else $error("violation flag raised by verify");
    reject_hold_a: assert property ( // RULE22
        launch && ck_acc |=> (command_complete_flag_q && (state_q == FCS_IDLE))[*2])
        else $error("rejected command started");
    ro_copy_a: assert property ( // RULE11
        start && (ck_cmd == CMD_RO) |=>
        (state_q == FCS_RUN)[*4] ##1 command_complete_flag_q)
        else $error("read-once did not take four cycles");
    ee_read_a: assert property ( // RULE21
        setup_acc && !pwrite && (paddr == OFS_WDATA) &&
        (state_q == FCS_RUN) &&
        ((cmd_q == CMD_PGEE) || ((cmd_q == CMD_EBLK) && sel_ee_q))
        |=> !pslverr)
        else $error("flash read refused during data op");

    evpf_cov_c: cover property (start && (ck_cmd == CMD_EVPF));
    blank_cov_c: cover property (blank_fail);
    prog_cov_c: cover property (start && (ck_cmd == CMD_PGEE));
    viol_cov_c: cover property (launch && ck_viol);
endmodule
`default_nettype wire

//--- fcs_flash_cmd_seq_tb.sv
`timescale 1ns/10ps
`default_nettype none
module fcs_flash_cmd_seq_tb
    import fcs_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [32:0] exp_q[$];
    logic [15:0] rw[4];
    logic [15:0] dirty;
    int          fails = 0;
    int          checks_done = 0;
    // Refused launches: param0, param1, param2, words loaded
    logic [15:0] bad[7][4] = '{
        '{16'h0303, 16'hf800, 16'h0001, 16'h2},
        '{16'h0300, 16'hf800, 16'h0001, 16'h3},
        '{16'h0303, 16'hf802, 16'h0001, 16'h3},
        '{16'h0303, 16'hfff8, 16'h0002, 16'h3},
        '{16'h0303, 16'hf800, 16'h0000, 16'h3},
        '{16'h0400, 16'h0008, 16'h0000, 16'h2},
        '{16'h0e00, 16'h0001, 16'h0000, 16'h2}};

    fcs_flash_cmd_seq fcs_flash_cmd_seq_i (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr)
    );

    initial begin
        forever #2.5 pclk = ~pclk;
    end

    // ------------------------------------------------
    // Bus tasks and answer checking
    // ------------------------------------------------
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, input logic [32:0] e);
        exp_q.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        xfer(1'b0, a, 32'h0, e);
    endtask

    task automatic cmd(input int n, input logic [15:0] p0, p1, p2,
                       input int t);
        logic [15:0] p[3];
        p = '{p0, p1, p2};
        for (int i = 0; i < n; i++) begin
            wr(OFS_PTR, 32'(i));
            wr(OFS_DATA, {16'h0, p[i]});
        end
        wr(OFS_STAT, 32'h80);
        repeat (t) @(posedge pclk);
    endtask

    task automatic check_answer(input logic [32:0] e);
        checks_done++;
        if ({pslverr, prdata} !== e) begin
            fails++;
            $display("unexpected answer: expected %h seen %h",
                     e, {pslverr, prdata});
        end
    endtask

    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            check_answer(exp_q.pop_front());
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (12000) @(posedge pclk);
        fails++;
        test_done();
    end

    // ------------------------------------------------
    // Test sequence
    // ------------------------------------------------
    initial begin
        void'($urandom(32'h6631663a));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(OFS_STAT, 33'h180);
        rd(8'h3c, 33'h1_0000_0000);
        $display("test reset done");
        foreach (bad[k]) begin
            cmd(int'(bad[k][3]), bad[k][0], bad[k][1], bad[k][2], 4);
            rd(OFS_STAT, 33'h1a0);
            wr(OFS_STAT, 32'h30);
        end
        $display("test refusals done");
        for (int i = 0; i < 8; i++) begin
            wr(OFS_WADDR, 32'(i));
            wr(OFS_WDATA, 32'hffff);
        end
        cmd(3, 16'h0303, 16'hf800, 16'h0002, 0);
        rd(OFS_STAT, 33'h100);
        repeat (12) @(posedge pclk);
        rd(OFS_STAT, 33'h180);
        dirty = {1'b0, 15'($urandom)};
        wr(OFS_WADDR, 32'h5);
        wr(OFS_WDATA, {16'h0, dirty});
        cmd(3, 16'h0303, 16'hf800, 16'h0002, 20);
        rd(OFS_STAT, 33'h183);
        $display("test verify done");
        for (int i = 0; i < 4; i++) begin
            rw[i] = 16'($urandom);
            wr(OFS_WADDR, 32'h40c + 32'(i));
            wr(OFS_WDATA, {16'h0, rw[i]});
        end
        cmd(2, 16'h0400, 16'h0003, 16'h0, 12);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_PTR, 32'(i + 2));
            rd(OFS_DATA, {17'h0, rw[i]});
        end
        wr(OFS_CFG, 32'h1);
        cmd(2, 16'h0e00, 16'h0004, 16'h0, 2);
        cmd(2, 16'h0d00, 16'h0002, 16'h0, 2);
        rd(OFS_MRG, 33'h42);
        cmd(3, 16'h1100, 16'h0400, {1'b0, 15'($urandom)}, 8);
        cmd(3, 16'h1000, 16'h0400, 16'h0001, 8);
        rd(OFS_STAT, 33'h183);
        cmd(2, 16'h1200, 16'h0400, 16'h0, 8);
        cmd(3, 16'h1000, 16'h0400, 16'h0001, 8);
        rd(OFS_STAT, 33'h180);
        wr(OFS_DPROT, 32'h1);
        cmd(2, 16'h0900, 16'h0400, 16'h0, 0);
        wr(OFS_WADDR, 32'h5);
        rd(OFS_WDATA, {17'h0, dirty});
        repeat (200) @(posedge pclk);
        rd(OFS_STAT, 33'h180);
        $display("test data array done");
        cmd(1, 16'h0800, 16'h0, 16'h0, 4);
        rd(OFS_STAT, 33'h190);
        wr(OFS_STAT, 32'h30);
        wr(OFS_PPROT, 32'h7);
        cmd(1, 16'h0800, 16'h0, 16'h0, 1100);
        rd(OFS_WDATA, 33'hffff);
        cmd(1, 16'h0b00, 16'h0, 16'h0, 1100);
        rd(OFS_STAT, 33'h080);
        wr(OFS_WDATA, {16'h0, dirty});
        cmd(2, 16'h0903, 16'hf800, 16'h0, 0);
        rd(OFS_WDATA, 33'h1_0000_0000);
        repeat (1100) @(posedge pclk);
        rd(OFS_WDATA, 33'hffff);
        $display("test mass erase done");
        test_done();
    end
endmodule
`default_nettype wire

//--- fcs_pkg.sv
`default_nettype none
package fcs_pkg;
    // -----------------------------------------------------------
    // Register byte offsets
    // -----------------------------------------------------------
    localparam logic [7:0] OFS_STAT  = 8'h00;
    localparam logic [7:0] OFS_PTR   = 8'h04;
    localparam logic [7:0] OFS_DATA  = 8'h08;
    localparam logic [7:0] OFS_PPROT = 8'h0c;
    localparam logic [7:0] OFS_DPROT = 8'h10;
    localparam logic [7:0] OFS_CFG   = 8'h14;
    localparam logic [7:0] OFS_MRG   = 8'h18;
    localparam logic [7:0] OFS_WADDR = 8'h1c;
    localparam logic [7:0] OFS_WDATA = 8'h20;
    // -----------------------------------------------------------
    // Field positions and reset values
    // -----------------------------------------------------------
    localparam int ST_MG0  = 0;
    localparam int ST_MG1  = 1;
    localparam int ST_VIOL = 4;
    localparam int ST_ACC  = 5;
    localparam int ST_COMMAND_COMPLETE_FLAG = 7;
    localparam int ST_SEC  = 8;
    localparam int MRG_FLD = 4;
    localparam logic [2:0] PPROT_ALL = 3'h7;
    localparam logic [2:0] PPROT_RST = 3'h0;
    localparam logic       DPROT_RST = 1'b0;
    localparam logic       CFG_RST   = 1'b0;
    localparam logic       SEC_RST   = 1'b1;
    // -----------------------------------------------------------
    // Command codes and parameter indices
    // -----------------------------------------------------------
    localparam logic [7:0] CMD_EVPF = 8'h03;
    localparam logic [7:0] CMD_RO   = 8'h04;
    localparam logic [7:0] CMD_EALL = 8'h08;
    localparam logic [7:0] CMD_EBLK = 8'h09;
    localparam logic [7:0] CMD_UNS  = 8'h0b;
    localparam logic [7:0] CMD_UMRG = 8'h0d;
    localparam logic [7:0] CMD_FMRG = 8'h0e;
    localparam logic [7:0] CMD_EVEE = 8'h10;
    localparam logic [7:0] CMD_PGEE = 8'h11;
    localparam logic [7:0] CMD_SEEE = 8'h12;
    localparam logic [2:0] IX_CMD  = 3'h0;
    localparam logic [2:0] IX_ADR  = 3'h1;
    localparam logic [2:0] IX_CNT  = 3'h2;
    localparam logic [2:0] IX_LAST = 3'h5;
    localparam logic [2:0] UMRG_MAX = 3'h2;
    localparam logic [2:0] FMRG_MAX = 3'h4;
    localparam logic [15:0] RO_MAX  = 16'h0007;
    // -----------------------------------------------------------
    // Array sizes and address map
    // -----------------------------------------------------------
    localparam int NPARAM   = 6;
    localparam int PF_WORDS = 1024;
    localparam int EE_WORDS = 128;
    localparam int RO_WORDS = 32;
    localparam logic [10:0] PF_LEN  = 11'h400;
    localparam logic [10:0] EE_LEN  = 11'h080;
    localparam logic [10:0] BLK_LEN = 11'h004;
    localparam logic [16:0] EE_LIM  = 17'h00080;
    localparam logic [17:0] PF_BASE = 18'h3f800;
    localparam logic [19:0] PF_SIZE = 20'h00800;
    localparam logic [17:0] EE_BASE = 18'h00400;
    localparam logic [17:0] EE_END  = 18'h00500;
    localparam logic [15:0] ERASED  = 16'hffff;
endpackage
`default_nettype wire

//--- fcs_pkg_unused_guard.sv
`default_nettype none
`default_nettype wire
